// File: hdl/dcs_defines.svh
// Purpose: constants of the daisy-chain serial config loader
// Assumes: pclk at 20 MHz
// Notes:   offsets are byte addresses on APB
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
`define DCS_PCLK_NS      50
`define DCS_PCLK_HZ      20000000
`define DCS_INIT_OSC_HZ  10000000
`define DCS_OSC_DIV      (`DCS_PCLK_HZ / `DCS_INIT_OSC_HZ)
`define DCS_RESTART_NS   40000
`define DCS_RESTART_CYC  (`DCS_RESTART_NS / `DCS_PCLK_NS)
`define DCS_INIT_CYC     299
`define DCS_SCLK_HALF    4
`define DCS_SEL_AS       2'h0
`define DCS_SEL_PS       2'h1
`define DCS_REG_CTRL     8'h00
`define DCS_REG_LEN      8'h04
`define DCS_REG_STAT     8'h08
`define DCS_REG_BITS     8'h0c
`define DCS_REG_WORD     8'h10
`define DCS_CTRL_AUTO    0
`define DCS_CTRL_UCLK    1
`define DCS_CTRL_PAR     2
`define DCS_CTRL_RST     3'h1
`define DCS_LEN_RST      32'h00000040
`endif

// File: hdl/dcs_loader.sv
// Purpose: one device of a serial configuration chain
// Assumes: pins wired-and outside; straps static
// Notes:   strap picks master (clock maker) or slave
//
// What the chain and this block must do
// [R1] after own bits, drive chain enable out low
// [R2] first device master, rest passive slaves
// [R3] chain shares reload, fault, done, clock, data
// [R4] fault and done lines are open-drain, read back
// [R5] release done together with chain enable out
// [R6] unloaded device holds done line low
// [R7] all enter init when done line rises
// [R8] init clocked by internal oscillator or user clock
// [R9] user clock option: init advances only on it
// [R10] detected error pulls fault line low
// [R11] auto-restart after at most 40 us timeout
// [R12] without auto-restart, controller pulses reload low
// [R13] user clock keeps toggling while fault low
// [R14] memory holds concatenated bitstreams in chain order
// [R15] master holds chain enable out high loading itself
// [R16] master keeps clocking second image to slaves
// [R17] slaves strapped to passive-serial code 01
// [R18] slave samples data on serial clock rise
// [R19] init takes 299 clocks after done rises
// [R20] reload pulse held low at least 2 us
// [R21] master drives and captures on clock fall
// [R22] slave ignores bits while chain enable high
// [R23] loaded device takes no further bits
`timescale 1ns/10ps
module dcs_loader
  import dcs_pkg::*;
#(
  parameter int LEN_W = 32
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // straps and chain
  input  wire logic [1:0]  scheme_select_pins,
  input  wire logic        chain_enable_in_n,
  output logic             chain_enable_out_n,
  input  wire logic        reload_request_n,
  // open-drain fault line
  input  wire logic        fault_line_n_in,
  output logic             fault_line_n_out,
  output logic             fault_line_n_oe_n,
  // open-drain done line
  input  wire logic        load_complete_in,
  output logic             load_complete_out,
  output logic             load_complete_oe_n,
  // serial load link
  input  wire logic        serial_load_clock_in,
  output logic             serial_load_clock_out,
  output logic             serial_load_clock_oe_n,
  input  wire logic        serial_load_data_in,
  // initialization
  input  wire logic        user_init_clock,
  output logic             user_mode
);
`include "dcs_defines.svh"

  dcs_state_e       state_reg;
  logic [8:0]       pin_q;
  logic [8:0]       pin_rise;
  logic [8:0]       pin_fall;
  logic [1:0]       sel_q;
  logic             ce_in_q;
  logic             reload_q;
  logic             fault_q;
  logic             done_q;
  logic             sclk_rise_q;
  logic             data_q;
  logic             uclk_rise_q;
  logic             slave_reg;
  logic [2:0]       ctrl_reg;
  logic [LEN_W-1:0] own_len_reg;
  logic [LEN_W-1:0] bit_cnt_reg;
  logic [31:0]      word_reg;
  logic [4:0]       frm_cnt_reg;
  logic             par_reg;
  logic             sclk_reg;
  logic             sclk_run;
  logic             div_zero;
  logic             osc_zero;
  logic             init_zero;
  logic             restart_zero;
  logic             master_fall;
  logic             accept;
  logic             own_done_hit;
  logic             frame_err;
  logic             init_tick;
  logic             setup;
  logic             wr_en;
  logic             mapped;
  logic [31:0]      rd_mux;

  // pin synchronisers
  dcs_sync #(
    .W (9)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scheme_select_pins, chain_enable_in_n, reload_request_n,
             fault_line_n_in, load_complete_in, serial_load_clock_in,
             serial_load_data_in, user_init_clock}),
    .q     (pin_q),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  assign sel_q       = pin_q[8:7];
  assign ce_in_q     = pin_q[6];
  assign reload_q    = pin_q[5];
  assign fault_q     = pin_q[4];
  assign done_q      = pin_q[3];
  assign sclk_rise_q = pin_rise[2];
  assign data_q      = pin_q[1];
  assign uclk_rise_q = pin_rise[0];

  // master serial clock divider
  assign sclk_run = !slave_reg &&
                    (state_reg == DCS_CONFIG || state_reg == DCS_WAIT_DONE); // [R16]

  dcs_timer #(
    .W (8)
  ) u_div (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (!sclk_run || div_zero),
    .load_val (8'(`DCS_SCLK_HALF - 1)),
    .tick     (1'b1),
    .zero     (div_zero)
  );

  // internal initialization oscillator
  dcs_timer #(
    .W (4)
  ) u_osc (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (osc_zero),
    .load_val (4'(`DCS_OSC_DIV - 1)),
    .tick     (1'b1),
    .zero     (osc_zero)
  );

  // initialization cycle counter
  assign init_tick = ctrl_reg[`DCS_CTRL_UCLK] ? uclk_rise_q : osc_zero; // [R8] [R9]

  dcs_timer #(
    .W (9)
  ) u_init (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (state_reg != DCS_INIT),
    .load_val (9'(`DCS_INIT_CYC)),
    .tick     (init_tick), // [R19]
    .zero     (init_zero)
  );

  // auto-restart timeout
  dcs_timer #(
    .W (10)
  ) u_restart (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (state_reg != DCS_ERROR),
    .load_val (10'(`DCS_RESTART_CYC - 1)),
    .tick     (1'b1),
    .zero     (restart_zero)
  );

  // bit acceptance
  assign master_fall = sclk_run && div_zero && sclk_reg;
  assign accept = state_reg == DCS_CONFIG && !ce_in_q && // [R22] [R23]
                  (slave_reg ? sclk_rise_q : master_fall); // [R18] [R21]
  assign own_done_hit = accept && (bit_cnt_reg == own_len_reg - 1'b1);
  assign frame_err = accept && ctrl_reg[`DCS_CTRL_PAR] &&
                     frm_cnt_reg == 5'h1f && (par_reg ^ data_q);

  // strap capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_reg <= 1'b0;
    end else if (state_reg == DCS_RESET) begin
      slave_reg <= (sel_q == `DCS_SEL_PS); // [R2] [R17]
    end
  end

  // configuration stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DCS_RESET;
    end else if (!reload_q) begin
      state_reg <= DCS_RESET; // [R12]
    end else begin
      unique case (state_reg)
        DCS_RESET: begin
          if (fault_q) begin
            state_reg <= DCS_CONFIG;
          end
        end
        DCS_CONFIG: begin
          if (frame_err) begin
            state_reg <= DCS_ERROR; // [R10]
          end else if (!fault_q) begin
            state_reg <= DCS_RESET;
          end else if (own_done_hit) begin
            state_reg <= DCS_WAIT_DONE;
          end
        end
        DCS_WAIT_DONE: begin
          if (!fault_q) begin
            state_reg <= DCS_RESET;
          end else if (done_q) begin
            state_reg <= DCS_INIT; // [R7]
          end
        end
        DCS_INIT: begin
          if (!fault_q) begin
            state_reg <= DCS_RESET;
          end else if (init_zero) begin
            state_reg <= DCS_USER; // [R19]
          end
        end
        DCS_USER: begin
          state_reg <= DCS_USER;
        end
        DCS_ERROR: begin
          if (ctrl_reg[`DCS_CTRL_AUTO] && restart_zero) begin
            state_reg <= DCS_RESET; // [R11]
          end
        end
        default: begin
          state_reg <= DCS_RESET;
        end
      endcase
    end
  end

  // bit counting and capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= '0;
      frm_cnt_reg <= '0;
      par_reg     <= 1'b0;
      word_reg    <= '0;
    end else if (state_reg == DCS_RESET) begin
      bit_cnt_reg <= '0;
      frm_cnt_reg <= '0;
      par_reg     <= 1'b0;
    end else if (accept) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      frm_cnt_reg <= frm_cnt_reg + 1'b1;
      par_reg     <= (frm_cnt_reg == 5'h1f) ? 1'b0 : (par_reg ^ data_q);
      word_reg    <= {word_reg[30:0], data_q};
    end
  end

  // master serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_reg <= 1'b1;
    end else if (!sclk_run) begin
      sclk_reg <= 1'b1;
    end else if (div_zero) begin
      sclk_reg <= ~sclk_reg; // [R21]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_load_clock_out  <= 1'b1;
      serial_load_clock_oe_n <= 1'b1;
    end else begin
      serial_load_clock_out  <= sclk_reg;
      serial_load_clock_oe_n <= !sclk_run;
    end
  end

  // chain enable out and done line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_enable_out_n <= 1'b1;
      load_complete_oe_n <= 1'b0;
    end else if (state_reg == DCS_WAIT_DONE || state_reg == DCS_INIT ||
                 state_reg == DCS_USER) begin
      chain_enable_out_n <= 1'b0; // [R1] [R16]
      load_complete_oe_n <= 1'b1; // [R5] [R4]
    end else begin
      chain_enable_out_n <= 1'b1; // [R15]
      load_complete_oe_n <= 1'b0; // [R6]
    end
  end

  // fault line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_line_n_oe_n <= 1'b0;
    end else begin
      fault_line_n_oe_n <= !(!reload_q || state_reg == DCS_ERROR); // [R10] [R4]
    end
  end

  assign fault_line_n_out  = 1'b0;
  assign load_complete_out = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_mode <= 1'b0;
    end else begin
      user_mode <= (state_reg == DCS_USER);
    end
  end

  // apb slave
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite && pready;
  assign mapped = paddr == `DCS_REG_CTRL || paddr == `DCS_REG_LEN ||
                  paddr == `DCS_REG_STAT || paddr == `DCS_REG_BITS ||
                  paddr == `DCS_REG_WORD;

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      `DCS_REG_CTRL: rd_mux = {29'h0, ctrl_reg};
      `DCS_REG_LEN:  rd_mux = 32'(own_len_reg);
      `DCS_REG_STAT: rd_mux = {24'h0, user_mode, fault_q, done_q,
                               chain_enable_out_n, slave_reg, state_reg};
      `DCS_REG_BITS: rd_mux = 32'(bit_cnt_reg);
      `DCS_REG_WORD: rd_mux = word_reg;
      default:       rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `DCS_CTRL_RST;
    end else if (wr_en && paddr == `DCS_REG_CTRL) begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_len_reg <= LEN_W'(`DCS_LEN_RST);
    end else if (wr_en && paddr == `DCS_REG_LEN) begin
      own_len_reg <= pwdata[LEN_W-1:0]; // [R14]
    end
  end

endmodule

// File: hdl/dcs_pkg.sv
// Purpose: types of the daisy-chain serial config loader
// Assumes: nothing
// Notes:   configuration stages
package dcs_pkg;
  typedef enum logic [2:0] {
    DCS_RESET = 3'b000,
    DCS_CONFIG = 3'b001,
    DCS_WAIT_DONE = 3'b010,
    DCS_INIT = 3'b011,
    DCS_USER = 3'b100,
    DCS_ERROR = 3'b101
  } dcs_state_e;
endpackage

// File: hdl/dcs_sync.sv
// Purpose: two-flop synchroniser with edge detect
// Assumes: inputs asynchronous to clk
// Notes:   stage one feeds stage two only
`timescale 1ns/10ps
module dcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign q    = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule

// File: hdl/dcs_timer.sv
// Purpose: loadable down-counter
// Assumes: load wins over tick
// Notes:   zero is high while the count is zero
`timescale 1ns/10ps
module dcs_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic              zero
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign zero = (cnt_reg == '0);
endmodule

// File: verif/dcs_loader_asserts.sv
// Purpose: port assertions of the chain loader
// Assumes: one pclk domain, presetn async low
// Notes:   bound after endmodule
`timescale 1ns/10ps
module dcs_loader_asserts (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // chain
  input wire logic       chain_enable_out_n,
  input wire logic       reload_request_n,
  input wire logic       fault_line_n_oe_n,
  input wire logic       load_complete_in,
  input wire logic       load_complete_oe_n,
  input wire logic       serial_load_clock_out,
  input wire logic       user_mode
);
  int unsigned done_cnt;
  // cycles the done line has stood high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_cnt <= 0;
    else if (!load_complete_in) done_cnt <= 0;
    else if (done_cnt < 1000) done_cnt <= done_cnt + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_reload;
    !reload_request_n [*5];
  endsequence
  AST_PREADY: assert property (s_setup |=> pready) else $error("no ready after setup");
  AST_ONE_READY: assert property (pready |=> !pready) else $error("ready too long");
  AST_SLVERR: assert property (s_setup ##0 paddr > 8'h10 |=> pslverr)
    else $error("unmapped not refused");
  AST_CE_DONE: assert property ($fell(chain_enable_out_n) |-> load_complete_oe_n)
    else $error("done not released with chain out");
  AST_HOLD_DONE: assert property (chain_enable_out_n |-> !load_complete_oe_n)
    else $error("done released before load");
  AST_USER_ENTRY: assert property ($rose(user_mode) |-> done_cnt >= 299)
    else $error("user mode too early");
  AST_USER_STAY: assert property (user_mode && reload_request_n && $past(reload_request_n)
    |=> user_mode) else $error("user mode lost");
  AST_RELOAD: assert property (s_reload |-> !fault_line_n_oe_n && chain_enable_out_n
    && !load_complete_oe_n && !user_mode) else $error("reload not obeyed");
  AST_SCLK_HALF: assert property ($rose(serial_load_clock_out)
    |-> serial_load_clock_out [*4]) else $error("master clock half short");
endmodule

bind dcs_loader dcs_loader_asserts i_dcs_loader_asserts (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .chain_enable_out_n, .reload_request_n, .fault_line_n_oe_n,
  .load_complete_in, .load_complete_oe_n, .serial_load_clock_out, .user_mode);

// File: verif/dcs_loader_tb.sv
// Purpose: self-checking bench of the chain loader
// Assumes: other chain members modelled by ext_done
// Notes:   seed 61, random words and lengths
`timescale 1ns/10ps
module dcs_loader_tb;
  import dcs_pkg::*;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, w;
  logic        pready, pslverr, e, ext_done = 1'h0, p_sclk;
  logic [1:0]  scheme_select_pins = 2'h1;
  logic        chain_enable_in_n = 1'h1, chain_enable_out_n, reload_request_n = 1'h1;
  logic        fault_line_n_in, fault_line_n_out, fault_line_n_oe_n;
  logic        load_complete_in, load_complete_out, load_complete_oe_n;
  logic        serial_load_clock_in, serial_load_clock_out, serial_load_clock_oe_n;
  logic        serial_load_data_in, user_init_clock = 1'h0, user_mode;
  int          fails = 0, n_compared = 0, cyc = 0, len, k;
  always #25 pclk = ~pclk;
  assign fault_line_n_in = fault_line_n_oe_n ? 1'h1 : fault_line_n_out;
  assign load_complete_in = (load_complete_oe_n ? 1'h1 : load_complete_out) & ext_done;
  assign serial_load_clock_in = serial_load_clock_oe_n ? p_sclk : serial_load_clock_out;
  dcs_loader i_dcs_loader (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .scheme_select_pins, .chain_enable_in_n, .chain_enable_out_n,
    .reload_request_n, .fault_line_n_in, .fault_line_n_out, .fault_line_n_oe_n,
    .load_complete_in, .load_complete_out, .load_complete_oe_n, .serial_load_clock_in,
    .serial_load_clock_out, .serial_load_clock_oe_n, .serial_load_data_in, .user_init_clock,
    .user_mode);
  dcs_partner i_dcs_partner (.master(scheme_select_pins == 2'h0), .mclk(serial_load_clock_in),
    .sclk(p_sclk), .sdata(serial_load_data_in));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic chk1(input string nm, input logic x, input logic g);
    chk(nm, {31'h0, x}, {31'h0, g});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(nm, x, r);
  endtask
  task automatic reload();
    reload_request_n <= 1'h0;
    tick(40);
    reload_request_n <= 1'h1;
    tick(6);
  endtask
  task automatic load();
    i_dcs_partner.send($urandom, len - 32);
    tick(2);
    i_dcs_partner.send(w, 32);
    tick(6);
  endtask
  initial begin
    void'($urandom(61));
    len = 32 + $urandom_range(15, 0);
    w = $urandom;
    tick(3);
    presetn <= 1'h1;
    tick(4);
    chk1("ce_out", 1'h1, chain_enable_out_n);
    chk1("done_oe", 1'h0, load_complete_oe_n);
    rd("ctrl", 8'h00, 32'h1);
    rd("len", 8'h04, 32'h40);
    rd("hole", 8'h20, 32'h0);
    chk1("slverr", 1'h1, e);
    apb(1'h1, 8'h04, 32'(len));
    i_dcs_partner.send(w, 8);
    tick(4);
    rd("bits_off", 8'h0c, 32'h0);
    chain_enable_in_n <= 1'h0;
    tick(4);
    load();
    rd("bits", 8'h0c, 32'(len));
    rd("word", 8'h10, w);
    chk1("ce_low", 1'h0, chain_enable_out_n);
    chk1("done_rel", 1'h1, load_complete_oe_n);
    rd("stat", 8'h08, 32'h4a);
    i_dcs_partner.send(~w, 4);
    tick(20);
    rd("bits_more", 8'h0c, 32'(len));
    chk1("held", 1'h0, user_mode);
    ext_done <= 1'h1;
    k = 0;
    while (user_mode !== 1'h1 && k < 700) begin
      tick(1);
      k++;
    end
    chk1("init_osc", 1'h1, k >= 596 && k <= 612);
    apb(1'h1, 8'h00, 32'h3);
    reload();
    chk1("ce_rl", 1'h1, chain_enable_out_n);
    ext_done <= 1'h0;
    load();
    ext_done <= 1'h1;
    tick(20);
    chk1("uclk_init", 1'h0, chain_enable_out_n);
    fork
      reload();
      repeat (23) begin
        user_init_clock <= 1'h1;
        tick(1);
        user_init_clock <= 1'h0;
        tick(1);
      end
    join
    chk1("uclk_rl", 1'h1, chain_enable_out_n);
    ext_done <= 1'h0;
    load();
    ext_done <= 1'h1;
    tick(700);
    chk1("uclk_hold", 1'h0, user_mode);
    repeat (298) begin
      user_init_clock <= 1'h1;
      tick(2);
      user_init_clock <= 1'h0;
      tick(2);
    end
    tick(6);
    chk1("uclk_298", 1'h0, user_mode);
    user_init_clock <= 1'h1;
    tick(8);
    chk1("uclk_299", 1'h1, user_mode);
    user_init_clock <= 1'h0;
    apb(1'h1, 8'h00, 32'h5);
    apb(1'h1, 8'h04, 32'h40);
    reload();
    ext_done <= 1'h0;
    w = {w[31:1], ^w[31:1]};
    i_dcs_partner.send(w, 32);
    tick(6);
    chk1("even_ok", 1'h1, fault_line_n_oe_n);
    i_dcs_partner.send({w[31:1], ~w[0]}, 32);
    tick(6);
    chk1("odd_err", 1'h0, fault_line_n_oe_n);
    k = 0;
    while (fault_line_n_oe_n !== 1'h1 && k < 900) begin
      tick(1);
      k++;
    end
    chk1("restart", 1'h1, k >= 785 && k <= 800);
    apb(1'h1, 8'h00, 32'h4);
    i_dcs_partner.send({w[31:1], ~w[0]}, 32);
    tick(900);
    chk1("no_auto", 1'h0, fault_line_n_oe_n);
    reload();
    chk1("reload_rel", 1'h1, fault_line_n_oe_n);
    scheme_select_pins <= 2'h0;
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h04, 32'(len));
    reload();
    tick(2);
    chk1("m_drive", 1'h0, serial_load_clock_oe_n);
    chk1("m_ce", 1'h1, chain_enable_out_n);
    k = 0;
    while (chain_enable_out_n !== 1'h0 && k < 2000) begin
      tick(1);
      k++;
    end
    chk1("m_time", 1'h1, k >= len * 8 - 16 && k <= len * 8 + 16);
    chk1("m_clock", 1'h0, serial_load_clock_oe_n);
    print_verdict();
  end
endmodule

// File: verif/dcs_partner.sv
// Purpose: serial memory and upstream link model
// Assumes: link clock 400 ns, idle low
// Notes:   data line pulled up when idle
`timescale 1ns/10ps
module dcs_partner (
  // mode and master clock
  input  wire logic master,
  input  wire logic mclk,
  // link
  output logic      sclk,
  output logic      sdata
);
  logic sbit = 1'h1;
  logic mbit = 1'h1;
  initial sclk = 1'h0;
  assign sdata = master ? mbit : sbit;
  // memory advances on the rise, stable at the fall
  always @(posedge mclk) if (master) mbit <= ~mbit;
  // bits sent in stream order, msb first
  task automatic send(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sbit <= w[i];
      #200 sclk <= 1'h1;
      #200 sclk <= 1'h0;
    end
    sbit <= 1'h1;
  endtask
endmodule
